/* rdyflg_pkg.sv */
/*
  Package for the ready-flag block: register offsets, field positions,
  reset values and the carrier structs shared by the design files.
  Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
*/
package rdyflg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] RDYFLG_OFS_STATUS = 4'h0;
    localparam logic [3:0] RDYFLG_OFS_MASK   = 4'h4;
    localparam logic [3:0] RDYFLG_OFS_MODE   = 4'h8;
    localparam logic [3:0] RDYFLG_OFS_RXDATA = 4'hC;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RDYFLG_BIT_REGISTER_ACCESS_READY_FLAG  = 2;
    localparam int RDYFLG_BIT_RECEIVE_READY_INTERRUPT  = 3;
    localparam int RDYFLG_BIT_XRDY  = 4;
    localparam int RDYFLG_BIT_MST   = 10;
    localparam int RDYFLG_BIT_RSTRL = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RDYFLG_RST_MODE = 32'h0000_0000;
    localparam logic [31:0] RDYFLG_RST_MASK = 32'h0000_0000;
    localparam logic [7:0]  RDYFLG_RST_DATA = 8'h00;

    // ------------------------------------------------------------
    // Carrier structs
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rx_load;
        logic [7:0] rx_byte;
        logic       tx_load;
        logic       regs_used;
        logic       regs_start;
    } rdyflg_eng_t;

    typedef struct packed {
        logic receive_ready_interrupt;
        logic register_access_ready_flag;
        logic xrdy;
    } rdyflg_flags_t;

    // Bus access decode used by rdyflg_top.
    function automatic logic rdyflg_hit(input logic [3:0] addr, input logic [3:0] ofs);
        return addr == ofs;
    endfunction

endpackage

/* rdyflg_bit.sv */
/*
  One sticky status flag with set, clear and reset-to-value inputs.
  Assumes all inputs are synchronous to i_clk.
*/
`timescale 1ns/1ps
module rdyflg_bit
    import rdyflg_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_flag
);

    logic next_flag;

    assign next_flag = i_set ? 1'b1 : (i_clr ? 1'b0 : o_flag);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_flag <= RST_VAL;
        else
            o_flag <= next_flag;
    end

endmodule // rdyflg_bit

/* rdyflg_rxreg.sv */
/*
  Receive data register: holds the byte moved out of the shift register.
  Assumes the load strobe comes from the engine on i_clk.
*/
`timescale 1ns/1ps
module rdyflg_rxreg
    import rdyflg_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_load,
    input  wire logic [7:0] i_byte,
    output logic [7:0]      o_byte
);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_byte <= RDYFLG_RST_DATA;
        else if (i_load)
            o_byte <= i_byte;
    end

endmodule // rdyflg_rxreg

/* rdyflg_top.sv */
/*
  Receive-ready and access-ready status flags with an Avalon-MM slave.
  Assumes the bus engine gives one-cycle strobes on i_clk.
*/
// Summary of operation
// - The receive-ready flag at status bit 3 sets when a byte is loaded into the receive data register.
// - Reading the receive data register clears the receive-ready flag.
// - Writing 1 to status bit 3 clears the receive-ready flag.
// - Writing 0 to the reset-release bit or a system reset clears the receive-ready flag.
// - The receive-ready flag is readable and drives its own masked interrupt request.
// - The access-ready flag at status bit 2 sets when address, data and command have been used.
// - The access-ready flag only sets while the master mode bit is on.
// - The access-ready flag clears when the engine starts using the current register contents.
// - Writing 1 to status bit 2 clears the access-ready flag.
// - The access-ready flag is readable and drives its own masked interrupt request.
// - The transmit-ready flag at bit 4 is forced to 1 on reset and set on a transmit load.
`timescale 1ns/1ps
module rdyflg_top
    import rdyflg_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire rdyflg_eng_t i_eng,
    output logic             o_receive_ready_interrupt_irq,
    output logic             o_register_access_ready_flag_irq,
    output logic             o_master_mode,
    output logic             o_module_reset_release_bit
);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle: the access is done in the cycle waitrequest is low.
    logic        ack;
    logic        rd_do;
    logic        wr_do;
    logic        hit_status;
    logic        hit_mask;
    logic        hit_mode;
    logic        hit_rxdata;
    logic        ctl_rst;
    logic        next_ack;
    logic [31:0] next_rdata;
    logic [31:0] mode_reg;
    logic [31:0] mask_reg;
    logic [7:0]  rx_byte;
    logic        receive_ready_interrupt;
    logic        register_access_ready_flag;
    logic        xrdy;
    logic        receive_ready_interrupt_clr;
    logic        register_access_ready_flag_clr;
    logic        xrdy_clr;
    logic        register_access_ready_flag_set;
    logic        lane0;

    assign next_ack   = (i_avs_read | i_avs_write) & ~ack;
    assign rd_do      = i_avs_read & ack;
    assign wr_do      = i_avs_write & ack;
    assign hit_status = rdyflg_hit(i_avs_address, RDYFLG_OFS_STATUS);
    assign hit_mask   = rdyflg_hit(i_avs_address, RDYFLG_OFS_MASK);
    assign hit_mode   = rdyflg_hit(i_avs_address, RDYFLG_OFS_MODE);
    assign hit_rxdata = rdyflg_hit(i_avs_address, RDYFLG_OFS_RXDATA);
    assign lane0      = i_avs_byteenable[0];

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            ack <= 1'b0;
        else
            ack <= next_ack;
    end

    always_comb
    begin
        o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [31:0] be_mask;
    assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mode_reg <= RDYFLG_RST_MODE;
            mask_reg <= RDYFLG_RST_MASK;
        end
        else if (wr_do)
        begin
            if (hit_mode)
                mode_reg <= (mode_reg & ~be_mask) | (i_avs_writedata & be_mask);
            if (hit_mask)
                mask_reg <= (mask_reg & ~be_mask) | (i_avs_writedata & be_mask);
        end
    end

    assign ctl_rst = i_sys_rst | ~mode_reg[RDYFLG_BIT_RSTRL];

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    // reading the receive data register clears the receive-ready flag.
    assign receive_ready_interrupt_clr = (rd_do & hit_rxdata) |
                      (wr_do & hit_status & lane0 & i_avs_writedata[RDYFLG_BIT_RECEIVE_READY_INTERRUPT]);
    assign register_access_ready_flag_clr = i_eng.regs_start |
                      (wr_do & hit_status & lane0 & i_avs_writedata[RDYFLG_BIT_REGISTER_ACCESS_READY_FLAG]);
    assign register_access_ready_flag_set = i_eng.regs_used & mode_reg[RDYFLG_BIT_MST];
    assign xrdy_clr = wr_do & hit_status & lane0 & i_avs_writedata[RDYFLG_BIT_XRDY];

    rdyflg_bit #(.RST_VAL(1'b0)) u_receive_ready_interrupt
    (
        .i_clk  (i_clk),
        .i_rst  (ctl_rst),
        .i_set  (i_eng.rx_load),
        .i_clr  (receive_ready_interrupt_clr),
        .o_flag (receive_ready_interrupt)
    );

    rdyflg_bit #(.RST_VAL(1'b0)) u_register_access_ready_flag
    (
        .i_clk  (i_clk),
        .i_rst  (ctl_rst | ~mode_reg[RDYFLG_BIT_MST]),
        .i_set  (register_access_ready_flag_set),
        .i_clr  (register_access_ready_flag_clr),
        .o_flag (register_access_ready_flag)
    );

    rdyflg_bit #(.RST_VAL(1'b1)) u_xrdy
    (
        .i_clk  (i_clk),
        .i_rst  (ctl_rst),
        .i_set  (i_eng.tx_load),
        .i_clr  (xrdy_clr),
        .o_flag (xrdy)
    );

    rdyflg_rxreg u_rxreg
    (
        .i_clk  (i_clk),
        .i_rst  (ctl_rst),
        .i_load (i_eng.rx_load),
        .i_byte (i_eng.rx_byte),
        .o_byte (rx_byte)
    );

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    logic [31:0] status_word;
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[RDYFLG_BIT_REGISTER_ACCESS_READY_FLAG] = register_access_ready_flag;
        status_word[RDYFLG_BIT_RECEIVE_READY_INTERRUPT] = receive_ready_interrupt;
        status_word[RDYFLG_BIT_XRDY] = xrdy;
    end

    assign next_rdata = ~i_avs_read ? 32'h0000_0000 :
                        hit_status  ? status_word :
                        hit_mask    ? mask_reg :
                        hit_mode    ? mode_reg :
                        hit_rxdata  ? {24'h00_0000, rx_byte} : 32'h0000_0000;

    // Read data is registered during the wait cycle and stands at the ack edge.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_avs_readdata             <= 32'h0000_0000;
            o_receive_ready_interrupt_irq                 <= 1'b0;
            o_register_access_ready_flag_irq                 <= 1'b0;
            o_master_mode              <= 1'b0;
            o_module_reset_release_bit <= 1'b0;
        end
        else
        begin
            o_avs_readdata             <= next_rdata;
            o_receive_ready_interrupt_irq                 <= receive_ready_interrupt & mask_reg[RDYFLG_BIT_RECEIVE_READY_INTERRUPT];
            o_register_access_ready_flag_irq                 <= register_access_ready_flag & mask_reg[RDYFLG_BIT_REGISTER_ACCESS_READY_FLAG];
            o_master_mode              <= mode_reg[RDYFLG_BIT_MST];
            o_module_reset_release_bit <= mode_reg[RDYFLG_BIT_RSTRL];
        end
    end

endmodule // rdyflg_top

/* rdyflg_checker.sv */
/* Assertions on the ports of the ready-flag block.
   Assumes mode and mask stay steady around engine events. */
`timescale 1ns/1ps
module rdyflg_checker
    import rdyflg_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic [3:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic        o_avs_waitrequest,
    input wire rdyflg_eng_t i_eng,
    input wire logic        o_receive_ready_interrupt_irq,
    input wire logic        o_register_access_ready_flag_irq,
    input wire logic        o_master_mode,
    input wire logic        o_module_reset_release_bit
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic [3:2] mask_q;
    wire take = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    wire wr_lane = take && i_avs_write && i_avs_byteenable[0];
    wire w1c = wr_lane && i_avs_address == RDYFLG_OFS_STATUS;
    always_ff @(posedge i_clk)
        if (i_sys_rst)
            mask_q <= 2'b00;
        else if (wr_lane && i_avs_address == RDYFLG_OFS_MASK)
            mask_q <= i_avs_writedata[3:2];
    sequence s_quiet;
        (!i_eng.rx_load && !i_eng.regs_used)[*3];
    endsequence
    sequence s_on;
        o_master_mode && o_module_reset_release_bit;
    endsequence
    AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest held too long");
    AST_RECEIVE_READY_INTERRUPT_SET: assert property (i_eng.rx_load && o_module_reset_release_bit && mask_q[3] |-> ##[1:3] o_receive_ready_interrupt_irq)
        else $error("receive ready not raised");
    AST_RECEIVE_READY_INTERRUPT_READ: assert property (take && i_avs_read && i_avs_address == RDYFLG_OFS_RXDATA ##0 s_quiet |=> !o_receive_ready_interrupt_irq)
        else $error("receive ready kept after data read");
    AST_RECEIVE_READY_INTERRUPT_W1C: assert property (w1c && i_avs_writedata[3] ##0 s_quiet |=> !o_receive_ready_interrupt_irq)
        else $error("receive ready kept after clear");
    AST_RST_OFF: assert property (!o_module_reset_release_bit [*2] |-> ##2 !(o_receive_ready_interrupt_irq || o_register_access_ready_flag_irq))
        else $error("flag active in controller reset");
    AST_REGISTER_ACCESS_READY_FLAG_SET: assert property (i_eng.regs_used && mask_q[2] ##0 s_on |-> ##[1:3] o_register_access_ready_flag_irq)
        else $error("access ready not raised");
    AST_SLAVE: assert property (!o_master_mode [*2] |-> ##2 !o_register_access_ready_flag_irq)
        else $error("access ready outside master mode");
    AST_REGISTER_ACCESS_READY_FLAG_START: assert property (i_eng.regs_start ##0 s_quiet |=> !o_register_access_ready_flag_irq)
        else $error("access ready kept after start");
    AST_REGISTER_ACCESS_READY_FLAG_W1C: assert property (w1c && i_avs_writedata[2] ##0 s_quiet |=> !o_register_access_ready_flag_irq)
        else $error("access ready kept after clear");
endmodule // rdyflg_checker

bind rdyflg_top rdyflg_checker rdyflg_checker_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_waitrequest(o_avs_waitrequest), .i_eng(i_eng), .o_receive_ready_interrupt_irq(o_receive_ready_interrupt_irq), .o_register_access_ready_flag_irq(o_register_access_ready_flag_irq),
    .o_master_mode(o_master_mode), .o_module_reset_release_bit(o_module_reset_release_bit));

/* rdyflg_eng_model.sv */
/* Bus engine model: turns bench requests into one-cycle strobes.
   Assumes requests arrive synchronous to i_clk. */
`timescale 1ns/1ps
module rdyflg_eng_model
    import rdyflg_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [3:0] i_go,
    input  wire logic [7:0] i_byte,
    output rdyflg_eng_t     o_eng
);
    initial o_eng = '0;
    // The byte lane toggles whenever no load is carried.
    always @(posedge i_clk)
    begin
        o_eng.rx_load <= i_go[0];
        o_eng.rx_byte <= i_go[0] ? i_byte : ~o_eng.rx_byte;
        o_eng.tx_load <= i_go[1];
        o_eng.regs_used <= i_go[2];
        o_eng.regs_start <= i_go[3];
    end
endmodule // rdyflg_eng_model

/* tb.sv */
/* Self-checking bench for the ready-flag block.
   Assumes one wait cycle per bus request. */
`timescale 1ns/1ps
module tb
    import rdyflg_pkg::*;
    ;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  go = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [7:0]  b;
    logic [7:0]  byt = 8'h00;
    logic        wt, rirq, airq;
    rdyflg_eng_t eng;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    integer      seed = 32'h3312;
    initial forever #12.5 clk = ~clk;
    rdyflg_eng_model rdyflg_eng_model_inst (.i_clk(clk), .i_go(go), .i_byte(byt), .o_eng(eng));
    rdyflg_top rdyflg_top_inst (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .i_eng(eng), .o_receive_ready_interrupt_irq(rirq), .o_register_access_ready_flag_irq(airq),
        .o_master_mode(), .o_module_reset_release_bit());
    function automatic logic [31:0] st(input logic r, input logic a);
        return {27'h000_0000, 1'b1, r, a, 2'b00};
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic eng_ev(input logic [3:0] k, input logic [7:0] v);
        @(posedge clk);
        go <= k;
        byt <= v;
        @(posedge clk);
        go <= 4'h0;
        repeat (4) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            err_count++;
            complete_run;
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, RDYFLG_OFS_STATUS, 32'h0000_0000);
        chk(q, st(1'b0, 1'b0));
        bus(1'b0, 4'h2, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        bus(1'b1, RDYFLG_OFS_MASK, 32'h0000_000C);
        bus(1'b1, RDYFLG_OFS_MODE, 32'h0000_0420);
        for (int i = 0; i < 24; i++)
        begin
            b = 8'($random(seed));
            eng_ev(4'b0001, b);
            chk({31'h0000_0000, rirq}, 32'h0000_0001);
            bus(1'b0, RDYFLG_OFS_STATUS, 32'h0000_0000);
            chk(q, st(1'b1, 1'b0));
            bus(b[0], b[0] ? RDYFLG_OFS_STATUS : RDYFLG_OFS_RXDATA, 32'h0000_0008);
            if (!b[0])
                chk(q, {24'h00_0000, b});
            bus(1'b0, RDYFLG_OFS_STATUS, 32'h0000_0000);
            chk(q, st(1'b0, 1'b0));
            eng_ev(4'b0100, b);
            chk({31'h0000_0000, airq}, 32'h0000_0001);
            bus(1'b0, RDYFLG_OFS_STATUS, 32'h0000_0000);
            chk(q, st(1'b0, 1'b1));
            if (b[1])
                eng_ev(4'b1000, b);
            else
                bus(1'b1, RDYFLG_OFS_STATUS, 32'h0000_0004);
            bus(1'b0, RDYFLG_OFS_STATUS, 32'h0000_0000);
            chk(q, st(1'b0, 1'b0));
        end
        $display("flag loop done");
        bus(1'b1, RDYFLG_OFS_MODE, 32'h0000_0020);
        eng_ev(4'b0110, 8'h00);
        bus(1'b0, RDYFLG_OFS_STATUS, 32'h0000_0000);
        chk(q, st(1'b0, 1'b0));
        eng_ev(4'b0001, 8'h5A);
        bus(1'b1, RDYFLG_OFS_MODE, 32'h0000_0000);
        bus(1'b0, RDYFLG_OFS_STATUS, 32'h0000_0000);
        chk(q, st(1'b0, 1'b0));
        $display("mode tests done");
        complete_run;
    end
endmodule // tb
